// file: dv/adc_offset_chop_calibration_tb.sv
`timescale 1ns/100ps
`default_nettype none
module adc_offset_chop_calibration_tb
  import adc_ctrl_pkg::*;
;
  // ==========================================================
  // Signals.
  logic        clk, reset, awvalid, awready, wvalid, wready, bvalid;
  logic        bready, arvalid, arready, rvalid, rready;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, rdVal;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, wResp, rResp, clkSrc;
  logic        sampleStart, sampleReady, intClk, centre, inv, se, tri3;
  logic [9:0]  sampleCode, trimP, trimN;
  logic        irq;
  logic [2:0]  delayCnt;
  logic [9:0]  trimShift;
  int          err_total, comparisons;
  logic [31:0] p0, p1;

  adc_offset_chop_calibration uut (
    .clk(clk), .reset(reset), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready),
    .araddr(araddr), .arvalid(arvalid), .arready(arready),
    .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .sampleStart(sampleStart), .sampleReady(sampleReady),
    .sampleCode(sampleCode), .internalClockSelect(intClk),
    .converterClockSource(clkSrc), .inputCentreSelect(centre),
    .polarityInvert(inv), .singleEndedSelect(se),
    .tripleRangeAttenuator(tri3), .positiveTrim(trimP),
    .negativeTrim(trimN), .conversionDoneIrq(irq));

  // ==========================================================
  // Clock and converter macro with offset 3.5 at centre scale.
  // Each trim moves its polarity's code by half its distance from neutral.
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  assign trimShift = $signed(inv ? trimN - 10'h200 : trimP - 10'h200) >>> 1;
  always @(posedge clk) begin
    if (sampleStart) begin
      sampleReady <= 1'b0;
      delayCnt    <= 3'h0;
    end else if (!sampleReady) begin
      delayCnt <= delayCnt + 3'h1;
      if (delayCnt == 3'h1)
        sampleCode <= (centre ? (inv ? 10'h1FC : 10'h203)
                              : (inv ? 10'h2D3 : 10'h12C)) + trimShift;
      if (delayCnt == 3'h4) sampleReady <= 1'b1;
    end
  end

  // ==========================================================
  // Bus tasks and checks.
  task automatic test_done;
    $display("checks %0d mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang;
    err_total++;
    $display("wrong value wait bound expected done seen timeout");
    test_done;
  endtask
  task automatic chk(input string nm, input logic [31:0] seen,
                     input logic [31:0] exp);
    comparisons++;
    if (seen !== exp) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    awaddr <= a; awvalid <= 1'b1; wdata <= d; wvalid <= 1'b1;
    bready <= 1'b1;
    while (1) begin
      @(posedge clk);
      n++;
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        wResp = bresp;
        bready <= 1'b0;
        break;
      end
      if (n > 50) hang;
    end
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    n = 0;
    araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
    while (1) begin
      @(posedge clk);
      n++;
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        rdVal = rdata; rResp = rresp;
        rready <= 1'b0;
        break;
      end
      if (n > 50) hang;
    end
    @(posedge clk);
  endtask
  task automatic convert(input logic [31:0] cfg, output logic [31:0] res);
    int n;
    n = 0;
    wr(CFG_OFS, cfg);
    wr(CTRL_OFS, 32'h0000_0001);
    rd(CTRL_OFS); chk("go busy", rdVal, 32'h1);
    do begin
      rd(CTRL_OFS);
      n++;
      if (n > 1000) hang;
    end while (rdVal[0] !== 1'b0);
    rd(STAT_OFS); chk("done status", rdVal, 32'h1);
    chk("irq up", irq, 1'b1);
    rd(RESULT_OFS); res = rdVal;
    wr(STAT_OFS, 32'h0000_0001);
    chk("irq clear", irq, 1'b0);
  endtask

  // ==========================================================
  // Tests.
  initial begin
    err_total = 0; comparisons = 0; reset = 1'b1;
    awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'hF;
    wvalid = 1'b0; bready = 1'b0; araddr = 8'h00; arvalid = 1'b0;
    rready = 1'b0; sampleReady = 1'b1; sampleCode = 10'h000;
    delayCnt = 3'h0;
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    @(posedge clk);
    chk("trimP port", trimP, TRIM_NEUTRAL);
    chk("trimN port", trimN, TRIM_NEUTRAL);
    rd(TRIMP_OFS); chk("trimP reg", rdVal, 32'h200);
    rd(8'h1C); chk("unmapped resp", rResp, RESP_SLVERR);
    chk("unmapped data", rdVal, 32'h0);
    wr(8'h20, 32'h1); chk("unmapped wr", wResp, RESP_SLVERR);
    chk("clk internal", intClk, 1'b1);
    $display("test reset done");
    wr(CFG_OFS, 32'h0000_201E);
    chk("outs", {clkSrc, tri3, se, centre, inv}, 6'h2F);
    chk("clk ext", intClk, 1'b0);
    wr(TRIMP_OFS, 32'h0000_03FF); wr(TRIMN_OFS, 32'h0000_0100);
    chk("trimP 3FF", trimP, 10'h3FF);
    chk("trimN 100", trimN, 10'h100);
    wr(RESULT_OFS, 32'h5); rd(RESULT_OFS); chk("ro", rdVal, 32'h0);
    $display("test registers done");
    wr(TRIMP_OFS, {22'h00_0000, TRIM_NEUTRAL});
    wr(TRIMN_OFS, {22'h00_0000, TRIM_NEUTRAL});
    wr(MASK_OFS, 32'h0000_0001);
    for (int k = 0; k < 8; k++) begin
      convert(32'h4 | (k << CFG_CNT_L), p0);
      chk("oversample sum", p0, 32'd515 << k);
    end
    $display("test oversampling done");
    convert(32'h0000_0105, p0);
    chk("swap sum", p0, 32'd2046);
    convert(32'h0000_000C, p0);
    convert(32'h0000_000E, p1);
    chk("mirror sum", p0 + p1, 32'd1023);
    wr(TRIMP_OFS, 32'h200 - 2 * (p0 - 32'h200));
    wr(TRIMN_OFS, 32'h200 - 2 * (p1 - 32'h200));
    chk("cal trimP", trimP, 10'h1FA);
    chk("cal trimN", trimN, 10'h208);
    convert(32'h0000_000C, p0);
    chk("cal centre", p0, 32'h0000_0200);
    convert(32'h0000_0000, p0);
    chk("plain code", p0, 32'h0000_0129);
    $display("test chop and calibration done");
    wr(MASK_OFS, 32'h0);
    wr(CTRL_OFS, 32'h0000_0001);
    repeat (60) @(posedge clk);
    rd(STAT_OFS); chk("masked status", rdVal, 32'h1);
    chk("masked irq", irq, 1'b0);
    wr(STAT_OFS, 32'h1); rd(STAT_OFS); chk("w1c", rdVal, 32'h0);
    $display("test mask done");
    test_done;
  end
endmodule
`default_nettype wire

// file: inc/adc_ctrl_pkg.sv
`default_nettype none
package adc_ctrl_pkg;
  // ==========================================================
  // Register map.
  localparam logic [7:0] CTRL_OFS   = 8'h00;
  localparam logic [7:0] CFG_OFS    = 8'h04;
  localparam logic [7:0] TRIMP_OFS  = 8'h08;
  localparam logic [7:0] TRIMN_OFS  = 8'h0C;
  localparam logic [7:0] RESULT_OFS = 8'h10;
  localparam logic [7:0] STAT_OFS   = 8'h14;
  localparam logic [7:0] MASK_OFS   = 8'h18;
  // ==========================================================
  // Field positions and values.
  localparam int CTRL_GO   = 0;
  localparam int CFG_SWAP  = 0;
  localparam int CFG_INV   = 1;
  localparam int CFG_CTR   = 2;
  localparam int CFG_SE    = 3;
  localparam int CFG_ATT   = 4;
  localparam int CFG_CNT_L = 8;
  localparam int CFG_CLK_L = 12;
  localparam logic [9:0] TRIM_NEUTRAL = 10'h200;
  localparam logic [1:0] RESP_OKAY    = 2'h0;
  localparam logic [1:0] RESP_SLVERR  = 2'h2;
  localparam logic [1:0] CLK_INTERNAL = 2'h0;
  localparam logic [2:0] CNT_MAX_LOG  = 3'h7;
  localparam int SAMPLE_WIDTH = 10;
  localparam int ACC_WIDTH    = 18;
  localparam int RESULT_SHIFT = 6;
  // ==========================================================
  // Settings that steer the converter.
  typedef struct packed {
    logic [1:0] clockSource;
    logic [2:0] countLog;
    logic       triple;
    logic       singleEnded;
    logic       centreSelect;
    logic       polarityInvert;
    logic       swapEnable;
  } cfg_t;
  typedef enum logic [1:0] {
    IDLE   = 2'b00,
    SAMPLE = 2'b01,
    WAIT   = 2'b11
  } state_t;
endpackage
`default_nettype wire

// file: rtl/adc_offset_chop_calibration.sv
// Contract
// [RL1] Oversampling runs the programmed conversions and sums them into the result.
// [RL2] Done clears conversion_go, returns to sampling and raises conversion_done_irq; the code returns to IDLE instead.
// [RL3] Conversion count takes powers of two from 1 to 128.
// [RL4] Offset swap takes two conversions with opposite input polarity.
// [RL5] A swapped pair sums to an 11-bit word, mid-scale 1023.
// [RL6] Code boundary 0x1FF/0x200 is the converter's natural zero.
// [RL7] Input-centre select ties the converter input to centre scale.
// [RL8] Polarity invert mirrors the code about mid-scale.
// [RL9] Trims shift offset in the network; 0x200 in both means none.
// [RL10] Software calibrates with centre input, both polarities, neutral trims.
// [RL11] Software writes trims as 0x200 minus scaled measured offset.
// [RL12] Software checks centre result lies near 0x200.
// [RL13] Trims can also move zero-scale or full-scale points.
// [RL14] Common mode uses equal trims 0x300, 0x200, 0x100.
// [RL15] Common-mode trim replaces 0x200 in the calibration sequence.
// [RL16] Clock source zero selects the internal fast SAR clock.
// [RL17] Each trim is a 10-bit field driven continuously to the converter.
`timescale 1ns/100ps
`default_nettype none
module adc_offset_chop_calibration
  import adc_ctrl_pkg::*;
(
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        reset,
  // AXI4-Lite write channels.
  input  wire logic [7:0]  awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  // AXI4-Lite read channels.
  input  wire logic [7:0]  araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  // Analog converter macro.
  output logic             sampleStart,
  input  wire logic        sampleReady,
  input  wire logic [9:0]  sampleCode,
  output logic             internalClockSelect,
  output logic [1:0]       converterClockSource,
  output logic             inputCentreSelect,
  output logic             polarityInvert,
  output logic             singleEndedSelect,
  output logic             tripleRangeAttenuator,
  output logic [9:0]       positiveTrim,
  output logic [9:0]       negativeTrim,
  // Interrupt.
  output logic             conversionDoneIrq
);
  // ==========================================================
  // Input synchronisers for the converter macro.
  logic       readyMeta_q, readySync_q;
  logic [9:0] codeMeta_q, codeSync_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      readyMeta_q <= 1'b0;
      readySync_q <= 1'b0;
      codeMeta_q  <= 10'h000;
      codeSync_q  <= 10'h000;
    end else begin
      readyMeta_q <= sampleReady;
      readySync_q <= readyMeta_q;
      codeMeta_q  <= sampleCode;
      codeSync_q  <= codeMeta_q;
    end
  end
  // ==========================================================
  // Bus decode.
  logic        awHeld_q, wHeld_q;
  logic [7:0]  awAddr_q;
  logic [31:0] wData_q;
  logic [3:0]  wStrb_q;
  wire         doWrite = awHeld_q && wHeld_q && !bvalid;
  wire         wrCtrl  = doWrite && awAddr_q == CTRL_OFS && wStrb_q[0];
  wire         wrCfg   = doWrite && awAddr_q == CFG_OFS;
  wire         wrTrimP = doWrite && awAddr_q == TRIMP_OFS;
  wire         wrTrimN = doWrite && awAddr_q == TRIMN_OFS;
  wire         wrStat  = doWrite && awAddr_q == STAT_OFS && wStrb_q[0];
  wire         wrMask  = doWrite && awAddr_q == MASK_OFS && wStrb_q[0];
  wire         wrHit   = wrCfg || wrTrimP || wrTrimN || wrMask || wrStat ||
                         awAddr_q == CTRL_OFS;
  assign awready = !awHeld_q;
  assign wready  = !wHeld_q;
  assign arready = !rvalid;
  // ==========================================================
  // Registers.
  cfg_t       cfg_q;
  logic [9:0] trimP_q, trimN_q;
  logic       go_q, stat_q, mask_q;
  logic [17:0] result_q;
  logic [31:0] cfgWord;
  always_comb begin
    cfgWord = 32'h0000_0000;
    cfgWord[CFG_SWAP]               = cfg_q.swapEnable;
    cfgWord[CFG_INV]                = cfg_q.polarityInvert;
    cfgWord[CFG_CTR]                = cfg_q.centreSelect;
    cfgWord[CFG_SE]                 = cfg_q.singleEnded;
    cfgWord[CFG_ATT]                = cfg_q.triple;
    cfgWord[CFG_CNT_L+2:CFG_CNT_L]  = cfg_q.countLog;
    cfgWord[CFG_CLK_L+1:CFG_CLK_L]  = cfg_q.clockSource;
  end
  cfg_t cfgNew;
  always_comb begin
    cfgNew.swapEnable     = wData_q[CFG_SWAP];
    cfgNew.polarityInvert = wData_q[CFG_INV];
    cfgNew.centreSelect   = wData_q[CFG_CTR];
    cfgNew.singleEnded    = wData_q[CFG_SE];
    cfgNew.triple         = wData_q[CFG_ATT];
    cfgNew.countLog       = wData_q[CFG_CNT_L+2:CFG_CNT_L]; // RL3
    cfgNew.clockSource    = wData_q[CFG_CLK_L+1:CFG_CLK_L];
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      cfg_q   <= '0;
      trimP_q <= TRIM_NEUTRAL; // RL9
      trimN_q <= TRIM_NEUTRAL; // RL9
      mask_q  <= 1'b0;
    end else begin
      if (wrCfg) cfg_q <= cfgNew;
      if (wrTrimP) trimP_q <= wData_q[9:0]; // RL17
      if (wrTrimN) trimN_q <= wData_q[9:0]; // RL17
      if (wrMask) mask_q <= wData_q[0];
    end
  end
  // ==========================================================
  // Write channel handshake.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      awHeld_q <= 1'b0;
      wHeld_q  <= 1'b0;
      awAddr_q <= 8'h00;
      wData_q  <= 32'h0000_0000;
      wStrb_q  <= 4'h0;
      bvalid   <= 1'b0;
      bresp    <= RESP_OKAY;
    end else begin
      if (awvalid && awready) begin
        awHeld_q <= 1'b1;
        awAddr_q <= awaddr;
      end
      if (wvalid && wready) begin
        wHeld_q <= 1'b1;
        wData_q <= wdata;
        wStrb_q <= wstrb;
      end
      if (doWrite) begin
        bvalid   <= 1'b1;
        bresp    <= wrHit ? RESP_OKAY : RESP_SLVERR;
        awHeld_q <= 1'b0;
        wHeld_q  <= 1'b0;
      end else if (bvalid && bready) begin
        bvalid <= 1'b0;
      end
    end
  end
  // ==========================================================
  // Read channel.
  logic [31:0] rdMux;
  wire         rdHit = araddr == CTRL_OFS || araddr == CFG_OFS ||
                       araddr == TRIMP_OFS || araddr == TRIMN_OFS ||
                       araddr == RESULT_OFS || araddr == STAT_OFS ||
                       araddr == MASK_OFS;
  always_comb begin
    unique case (araddr)
      CTRL_OFS:   rdMux = {31'h0000_0000, go_q};
      CFG_OFS:    rdMux = cfgWord;
      TRIMP_OFS:  rdMux = {22'h00_0000, trimP_q};
      TRIMN_OFS:  rdMux = {22'h00_0000, trimN_q};
      RESULT_OFS: rdMux = {14'h0000, result_q};
      STAT_OFS:   rdMux = {31'h0000_0000, stat_q};
      MASK_OFS:   rdMux = {31'h0000_0000, mask_q};
      default:    rdMux = 32'h0000_0000;
    endcase
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      rvalid <= 1'b0;
      rdata  <= 32'h0000_0000;
      rresp  <= RESP_OKAY;
    end else if (arvalid && arready) begin
      rvalid <= 1'b1;
      rdata  <= rdMux;
      rresp  <= rdHit ? RESP_OKAY : RESP_SLVERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
    end
  end
  // ==========================================================
  // Conversion sequencer.
  state_t      state_q;
  logic [7:0]  left_q;
  logic [17:0] acc_q;
  logic        flip_q;
  wire  [7:0]  total = 8'h01 << cfg_q.countLog; // RL3
  wire  [8:0]  pairs = cfg_q.swapEnable ? {total, 1'b0} : {1'b0, total};
  // Opposite polarity codes are summed raw; a mirrored pair adds to
  // 1023 in 11 bits, so no digital correction is applied.
  wire  [17:0] accNext = acc_q + {8'h00, codeSync_q}; // RL5
  wire         lastOne = left_q == 8'h01 && !(cfg_q.swapEnable && !flip_q);
  wire         finish  = state_q == WAIT && readySync_q && lastOne;
  logic [8:0]  convSeen_q;
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      convSeen_q <= 9'h000;
    end else if (state_q == IDLE) begin
      convSeen_q <= 9'h000;
    end else if (state_q == WAIT && readySync_q) begin
      convSeen_q <= convSeen_q + 9'h001;
    end
  end
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q  <= IDLE;
      left_q   <= 8'h00;
      acc_q    <= 18'h00000;
      flip_q   <= 1'b0;
      go_q     <= 1'b0;
      result_q <= 18'h00000;
    end else begin
      unique case (state_q)
        IDLE: if (wrCtrl && wData_q[CTRL_GO] && !go_q) begin
          go_q    <= 1'b1;
          left_q  <= total;
          acc_q   <= 18'h00000;
          flip_q  <= 1'b0;
          state_q <= SAMPLE;
        end
        SAMPLE: if (!readySync_q) state_q <= WAIT;
        WAIT: if (readySync_q) begin
          acc_q <= accNext; // RL1
          if (finish) begin
            result_q <= accNext;
            flip_q   <= 1'b0; // RL8
            go_q     <= 1'b0; // RL2
            state_q  <= IDLE; // RL2
          end else begin
            if (cfg_q.swapEnable) flip_q <= !flip_q; // RL4
            if (!cfg_q.swapEnable || flip_q) left_q <= left_q - 8'h01;
            state_q <= SAMPLE;
          end
        end
        default: state_q <= IDLE;
      endcase
    end
  end
  // ==========================================================
  // Interrupt status; a new event wins over a clear.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) stat_q <= 1'b0;
    else if (finish) stat_q <= 1'b1; // RL2
    else if (wrStat && wData_q[0]) stat_q <= 1'b0;
  end
  assign conversionDoneIrq = stat_q && mask_q; // RL2
  // ==========================================================
  // Converter drive.
  assign sampleStart = state_q == SAMPLE;
  // The code split at 0x1FF/0x200 is kept as the converter's zero. RL6
  assign inputCentreSelect     = cfg_q.centreSelect; // RL7
  assign polarityInvert        = cfg_q.polarityInvert ^ flip_q; // RL8
  assign singleEndedSelect     = cfg_q.singleEnded;
  assign tripleRangeAttenuator = cfg_q.triple;
  assign positiveTrim          = trimP_q; // RL13
  assign negativeTrim          = trimN_q; // RL13
  assign converterClockSource  = cfg_q.clockSource;
  assign internalClockSelect   = cfg_q.clockSource == CLK_INTERNAL; // RL16
  // ==========================================================
  // Checks.
  done_clears_a: assert property (@(posedge clk) disable iff (reset) // RL2
    finish |=> !go_q && state_q == IDLE) else $error("go not cleared");
  done_irq_a: assert property (@(posedge clk) disable iff (reset) // RL2
    finish |=> stat_q) else $error("status not set");
  trim_reset_a: assert property (@(posedge clk) // RL9
    $fell(reset) |-> positiveTrim == TRIM_NEUTRAL &&
    negativeTrim == TRIM_NEUTRAL) else $error("trim not neutral");
  trim_hold_a: assert property (@(posedge clk) disable iff (reset) // RL17
    !wrTrimP |=> $stable(positiveTrim)) else $error("trim drift");
  clock_sel_a: assert property (@(posedge clk) disable iff (reset) // RL16
    converterClockSource == CLK_INTERNAL |-> internalClockSelect)
    else $error("clock select wrong");
  centre_drive_a: assert property (@(posedge clk) disable iff (reset) // RL7
    wrCfg |=> inputCentreSelect == wData_q[CFG_CTR])
    else $error("centre not driven");
  swap_flip_a: assert property (@(posedge clk) disable iff (reset) // RL4
    state_q == WAIT && readySync_q && !finish && cfg_q.swapEnable
    |=> $changed(polarityInvert)) else $error("no swap");
  accum_sum_a: assert property (@(posedge clk) disable iff (reset) // RL1
    finish |=> result_q == $past(accNext)) else $error("bad sum");
  count_span_a: assert property (@(posedge clk) disable iff (reset) // RL3
    finish |-> convSeen_q + 9'h001 == pairs) else $error("count wrong");
  cover_single_c: cover property (@(posedge clk)
    finish && cfg_q.countLog == 3'h0);
  cover_over_c: cover property (@(posedge clk)
    finish && cfg_q.countLog == CNT_MAX_LOG);
  cover_swap_c: cover property (@(posedge clk)
    finish && cfg_q.swapEnable);
endmodule
`default_nettype wire
